// file: phcr_pkg.sv
// Purpose: constants for the pin hold and loop control register bank
// Assumes: byte-wide registers at printed byte offsets, one core clock
// Notes: all registers reset to zero
// Behaviour
// - setting a hold bit from zero to one freezes that pin's current level in input value
// - with hold bit zero, input value follows the live pin level
// - upper page selection register mirrors the lower page selection register
// - first loop quick-acquire bit 0 enables its feature, resets zero
// - second loop quick-acquire bit 0 enables independently, bits 7:1 reserved
// - first loop averaging field bits 3:0, zero bypasses the filter
// - nonzero setting n selects bandwidth 343/(2^n*2*pi) hertz
// - second loop averaging field same encoding, bits 7:4 reserved
// - input value reports pin only in function zero with output enable zero
package phcr_pkg;
  localparam int          PHCR_AW           = 10;
  localparam logic [9:0]  PHCR_INPUT_VALUE  = 10'h276;
  localparam logic [9:0]  PHCR_HOLD_CTRL    = 10'h27c;
  localparam logic [9:0]  PHCR_PAGE_LOWER   = 10'h07f;
  localparam logic [9:0]  PHCR_PAGE_UPPER   = 10'h27f;
  localparam logic [9:0]  PHCR_LOOP0_QA     = 10'h2c2;
  localparam logic [9:0]  PHCR_LOOP1_QA     = 10'h2c5;
  localparam logic [9:0]  PHCR_LOOP0_BW     = 10'h2d4;
  localparam logic [9:0]  PHCR_LOOP1_BW     = 10'h2d5;
  localparam logic [7:0]  PHCR_RESET_VAL    = 8'h00;
  localparam logic [7:0]  PHCR_HOLD_MASK    = 8'h7f;
  localparam logic [7:0]  PHCR_QA_MASK      = 8'h01;
  localparam logic [7:0]  PHCR_BW_MASK      = 8'h0f;
  localparam logic [7:0]  PHCR_FUNC_PLAIN   = 8'h00;
  localparam int          PHCR_PINS         = 7;
endpackage

// file: phcr_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage read only by the second
`timescale 1ns/10ps
module phcr_sync #(
  parameter int W = 7
) (
  input  wire logic         sys_clk,  // core clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic [W-1:0] d_async,  // raw inputs
  output logic      [W-1:0] d_sync    // synchronised inputs
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      d_sync <= '0;
    end else begin
      meta_q <= d_async;
      d_sync <= meta_q;
    end
  end
endmodule

// file: phcr_regs.sv
// Purpose: pin input hold, page selection and loop control register bank
// Assumes: plain register port, read data one cycle after read strobe
// Notes: unmapped addresses read zero and ignore writes
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module phcr_regs
  import phcr_pkg::*;
#(
  parameter int PINS = PHCR_PINS
) (
  input  wire logic              sys_clk,          // core clock, 10 MHz
  input  wire logic              rst_n,            // async reset, active low
  input  wire logic [PHCR_AW-1:0] reg_addr,        // register byte address
  input  wire logic [7:0]        reg_wdata,        // write data
  input  wire logic              reg_wr,           // write strobe
  input  wire logic              reg_rd,           // read strobe
  output logic      [7:0]        reg_rdata,        // read data, cycle after strobe
  input  wire logic [PINS-1:0]   pin_level,        // live pin levels
  input  wire logic [PINS-1:0]   pin_out_en,       // per-pin output enable
  input  wire logic [PINS*8-1:0] pin_function_sel, // per-pin function, 8 bits each
  output logic      [PINS-1:0]   pin_input_value,  // reported input values
  output logic      [7:0]        page_select,      // shared page selection
  output logic                   loop0_quick_en,   // first loop quick acquire
  output logic                   loop1_quick_en,   // second loop quick acquire
  output logic      [3:0]        loop0_avg_bw,     // first loop averaging setting
  output logic                   loop0_avg_bypass, // first loop filter bypassed
  output logic      [3:0]        loop1_avg_bw,     // second loop averaging setting
  output logic                   loop1_avg_bypass  // second loop filter bypassed
);
  if (PINS < 1 || PINS > 7) begin : g_chk
    $error("phcr_regs: PINS must be 1..7");
  end

  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] hold_q;
  logic [PINS-1:0] held_val_q;
  logic [7:0]      page_q;
  logic [7:0]      qa0_q;
  logic [7:0]      qa1_q;
  logic [7:0]      bw0_q;
  logic [7:0]      bw1_q;
  logic [7:0]      rdata_d;
  logic [PINS-1:0] value_d;
  logic            wr_hold;

  phcr_sync #(
    .W(PINS)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d_async (pin_level),
    .d_sync  (pin_sync)
  );

  assign wr_hold = reg_wr && (reg_addr == PHCR_HOLD_CTRL);

  // hold control, reserved bit 7 never stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (wr_hold) begin
      hold_q <= reg_wdata[PINS-1:0];
    end
  end

  // per-pin capture and reported value
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic is_input;
    assign is_input = (pin_function_sel[i*8 +: 8] == PHCR_FUNC_PLAIN) && !pin_out_en[i];

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        held_val_q[i] <= 1'b0;
      end else if (wr_hold && reg_wdata[i] && !hold_q[i]) begin
        held_val_q[i] <= pin_sync[i];
      end
    end

    always_comb begin
      if (!is_input) begin
        value_d[i] = 1'b0;
      end else if (hold_q[i]) begin
        value_d[i] = held_val_q[i];
      end else begin
        value_d[i] = pin_sync[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_input_value <= '0;
    end else begin
      pin_input_value <= value_d;
    end
  end

  // one page register seen at both addresses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= PHCR_RESET_VAL;
    end else if (reg_wr && (reg_addr == PHCR_PAGE_UPPER || reg_addr == PHCR_PAGE_LOWER)) begin
      page_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      qa0_q <= PHCR_RESET_VAL;
      qa1_q <= PHCR_RESET_VAL;
    end else begin
      if (reg_wr && reg_addr == PHCR_LOOP0_QA) begin
        qa0_q <= reg_wdata & PHCR_QA_MASK;
      end
      if (reg_wr && reg_addr == PHCR_LOOP1_QA) begin
        qa1_q <= reg_wdata & PHCR_QA_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bw0_q <= PHCR_RESET_VAL;
      bw1_q <= PHCR_RESET_VAL;
    end else begin
      if (reg_wr && reg_addr == PHCR_LOOP0_BW) begin
        bw0_q <= reg_wdata & PHCR_BW_MASK;
      end
      if (reg_wr && reg_addr == PHCR_LOOP1_BW) begin
        bw1_q <= reg_wdata & PHCR_BW_MASK;
      end
    end
  end

  // page and loop control outputs; nonzero setting n gives 343/(2^n*2*pi) Hz in the loop filter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_select      <= PHCR_RESET_VAL;
      loop0_quick_en   <= 1'b0;
      loop1_quick_en   <= 1'b0;
      loop0_avg_bw     <= 4'h0;
      loop1_avg_bw     <= 4'h0;
      loop0_avg_bypass <= 1'b1;
      loop1_avg_bypass <= 1'b1;
    end else begin
      page_select      <= page_q;
      loop0_quick_en   <= qa0_q[0];
      loop1_quick_en   <= qa1_q[0];
      loop0_avg_bw     <= bw0_q[3:0];
      loop1_avg_bw     <= bw1_q[3:0];
      loop0_avg_bypass <= (bw0_q[3:0] == 4'h0);
      loop1_avg_bypass <= (bw1_q[3:0] == 4'h0);
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      PHCR_INPUT_VALUE: rdata_d[PINS-1:0] = pin_input_value;
      PHCR_HOLD_CTRL:   rdata_d[PINS-1:0] = hold_q;
      PHCR_PAGE_UPPER:  rdata_d = page_q;
      PHCR_PAGE_LOWER:  rdata_d = page_q;
      PHCR_LOOP0_QA:    rdata_d = qa0_q;
      PHCR_LOOP1_QA:    rdata_d = qa1_q;
      PHCR_LOOP0_BW:    rdata_d = bw0_q;
      PHCR_LOOP1_BW:    rdata_d = bw1_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// file: phcr_regs_sva.sv
// Purpose: port checks for the register bank
// Assumes: outputs follow a write two edges later
// Notes: bound from tb_top
`timescale 1ns/10ps
module phcr_regs_sva
  import phcr_pkg::*;
(
  input wire logic         sys_clk,          // clock
  input wire logic         rst_n,            // reset
  input wire logic [9:0]   reg_addr,         // address
  input wire logic [7:0]   reg_wdata,        // write data
  input wire logic         reg_wr,           // write
  input wire logic         reg_rd,           // read
  input wire logic [7:0]   reg_rdata,        // read data
  input wire logic [6:0]   pin_input_value,  // pin values
  input wire logic [7:0]   page_select,      // page
  input wire logic         loop0_quick_en,   // loop0 enable
  input wire logic         loop1_quick_en,   // loop1 enable
  input wire logic [3:0]   loop0_avg_bw,     // loop0 setting
  input wire logic         loop0_avg_bypass, // loop0 bypass
  input wire logic [3:0]   loop1_avg_bw,     // loop1 setting
  input wire logic         loop1_avg_bypass  // loop1 bypass
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_qa0_follow: assert property (reg_wr && reg_addr == PHCR_LOOP0_QA |-> ##2 loop0_quick_en == $past(reg_wdata[0], 2))
    else $error("loop0 enable mismatch");
  chk_qa1_follow: assert property (reg_wr && reg_addr == PHCR_LOOP1_QA |-> ##2 loop1_quick_en == $past(reg_wdata[0], 2))
    else $error("loop1 enable mismatch");
  chk_bw0_follow: assert property (reg_wr && reg_addr == PHCR_LOOP0_BW |-> ##2 loop0_avg_bw == $past(reg_wdata[3:0], 2))
    else $error("loop0 setting mismatch");
  chk_bw1_follow: assert property (reg_wr && reg_addr == PHCR_LOOP1_BW |-> ##2 loop1_avg_bw == $past(reg_wdata[3:0], 2))
    else $error("loop1 setting mismatch");
  chk_bypass_pair: assert property ((loop0_avg_bypass == (loop0_avg_bw == 4'h0)) && (loop1_avg_bypass == (loop1_avg_bw == 4'h0)))
    else $error("bypass disagrees with setting");
  chk_page_mirror: assert property (reg_wr && (reg_addr == PHCR_PAGE_UPPER || reg_addr == PHCR_PAGE_LOWER) |-> ##2 page_select == $past(reg_wdata, 2))
    else $error("page select mismatch");
  chk_hold_freeze: assert property (reg_wr && reg_addr == PHCR_HOLD_CTRL && reg_wdata == 8'h7f ##1 !(reg_wr && reg_addr == PHCR_HOLD_CTRL) |=> $stable(pin_input_value))
    else $error("held value moved");
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: 10 MHz clock, ten reset cycles
// Notes: xorshift stimulus with a fixed seed
`timescale 1ns/10ps
module tb_top
  import phcr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  pin_level = 7'h00;
  logic [6:0]  pin_out_en = 7'h00;
  logic [55:0] pin_function_sel = 56'h0;
  logic [7:0]  reg_rdata, page_select;
  logic [6:0]  pin_input_value, lv;
  logic [3:0]  loop0_avg_bw, loop1_avg_bw;
  logic        loop0_quick_en, loop1_quick_en, loop0_avg_bypass, loop1_avg_bypass;
  logic [31:0] seed = 32'h75652664;
  logic [31:0] rnd;
  logic [9:0]  a;
  logic [9:0]  regs [6] = '{PHCR_HOLD_CTRL, PHCR_PAGE_UPPER, PHCR_LOOP0_QA, PHCR_LOOP1_QA, PHCR_LOOP0_BW, PHCR_LOOP1_BW};
  int          fail_count = 0;
  int          checks = 0;
  phcr_regs u_phcr_regs (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_level,
    .pin_out_en, .pin_function_sel, .pin_input_value, .page_select, .loop0_quick_en, .loop1_quick_en,
    .loop0_avg_bw, .loop0_avg_bypass, .loop1_avg_bw, .loop1_avg_bypass);
  initial forever #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // readable bits of each writable register
  function automatic logic [7:0] mask_of(logic [9:0] ad);
    case (ad)
      PHCR_HOLD_CTRL: return 8'h7f;
      PHCR_LOOP0_QA, PHCR_LOOP1_QA: return 8'h01;
      PHCR_LOOP0_BW, PHCR_LOOP1_BW: return 8'h0f;
      PHCR_PAGE_UPPER, PHCR_PAGE_LOWER: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [9:0] ad, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [9:0] ad, logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic pins(logic [6:0] exp);
    repeat (4) @(posedge sys_clk);
    #1 check("pin_input_value", {1'b0, pin_input_value}, {1'b0, exp});
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) begin
      wr(regs[i], 8'hff);
      rd(regs[i], mask_of(regs[i]));
    end
    rd(PHCR_PAGE_LOWER, 8'hff);
    wr(PHCR_PAGE_LOWER, 8'h5a);
    rd(PHCR_PAGE_UPPER, 8'h5a);
    wr(10'h100, 8'hff);
    rd(10'h100, 8'h00);
    wr(PHCR_HOLD_CTRL, 8'h00);
    for (int n = 0; n < 16; n++) begin
      wr(PHCR_LOOP0_BW, 8'(n));
      wr(PHCR_LOOP1_BW, 8'(15 - n));
      repeat (2) @(posedge sys_clk);
      #1 check("loop0_avg_bypass", {7'h0, loop0_avg_bypass}, {7'h0, n == 0});
      check("loop1_avg_bypass", {7'h0, loop1_avg_bypass}, {7'h0, n == 15});
      check("loop0_avg_bw", {4'h0, loop0_avg_bw}, 8'(n));
      check("loop1_avg_bw", {4'h0, loop1_avg_bw}, 8'(15 - n));
    end
    repeat (40) begin
      rnd = xs();
      a = regs[1 + rnd[10:8] % 5];
      wr(a, rnd[7:0]);
      rd(a, rnd[7:0] & mask_of(a));
    end
    repeat (5) begin
      rnd = xs();
      @(posedge sys_clk);
      pin_level <= rnd[6:0];
      pins(rnd[6:0]);
    end
    lv = pin_level;
    wr(PHCR_HOLD_CTRL, 8'h7f);
    @(posedge sys_clk);
    pin_level <= ~lv;
    pins(lv);
    rd(PHCR_INPUT_VALUE, {1'b0, lv});
    wr(PHCR_HOLD_CTRL, 8'h00);
    pins(~lv);
    @(posedge sys_clk);
    pin_level <= 7'h7f;
    pin_out_en <= 7'h09;
    pin_function_sel <= 56'h00_0000_0001_0000;
    pins(7'h72);
    print_verdict();
  end
endmodule
bind phcr_regs phcr_regs_sva u_phcr_regs_sva (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pin_input_value, .page_select, .loop0_quick_en, .loop1_quick_en, .loop0_avg_bw,
  .loop0_avg_bypass, .loop1_avg_bw, .loop1_avg_bypass);
